// ==== rtl/alrt_core.sv ====
// Analog terminal function mapping, reference loss detection, reference saving, torque detection.
`timescale 1ns/1ns
// Function
// R1: Function codes 7 and 8 route the terminal to torque limit A and B.
// R2: Under torque control, codes 10 and 11 give torque and torque current commands.
// R3: Codes 17 and 18 give forward and reverse speed limits.
// R4: Code 20 makes the input a monitor value for the communications link.
// R5: Same function on several terminals: first beats second, second beats third.
// R6: Save mode 0 stores the keypad reference at main power-off, restores at power-on.
// R7: Save mode 1 stores only on save key; power-on restores the last save.
// R8: Command below 10% of sampled level within 400 ms declares a wire break.
// R9: After a break, command above the recovery level clears it and is followed again.
// R10: Loss setting 0 stops, 20 to 120 percent continues, 999 disables substitution.
// R11: Setting 999 still flags the loss but keeps following the analog command.
// R12: Setting 0 or 999 uses recovery level of sampled level times 0.2.
// R13: Setting 100 percent or higher uses the sampled level itself for recovery.
// R14: The frequency command is sampled at a regular interval as level f1.
// R15: Loss detection uses the unfiltered input, ignoring filter time constants.
// R16: First torque detection output uses the first level and first timer.
// R17: Second torque detection and low torque outputs share the second level and timer.
// R18: Levels span 0 to 300 percent, timers 0.01 to 600.00 seconds.
// R19: Torque detection turns on after timer above level, off below level minus 5%.
// R20: Low torque turns on after timer below level, off above level plus 5%.
// R21: Loss window and torque timers count a fixed tick and clear at reset.
module alrt_core
  import alrt_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [AW-1:0] ain_a,
  input wire logic [AW-1:0] ain_b,
  input wire logic [AW-1:0] ain_c,
  input wire logic [AW-1:0] ain_freq_raw,
  input wire logic [FW-1:0] analog_in_a_function,
  input wire logic [FW-1:0] analog_in_b_function,
  input wire logic [FW-1:0] analog_in_c_function,
  input wire logic torque_control_select,
  input wire logic ref_save_mode,
  input wire logic [RW-1:0] ref_loss_ratio,
  input wire logic [AW-1:0] keypad_ref,
  input wire logic keypad_ref_load,
  input wire logic [AW-1:0] nv_read_data,
  input wire logic main_power_fail,
  input wire logic save_key,
  input wire logic [TQW-1:0] torque_calc,
  input wire logic [TQW-1:0] torque_level_one,
  input wire logic [TMW-1:0] torque_timer_one,
  input wire logic [TQW-1:0] torque_level_two,
  input wire logic [TMW-1:0] torque_timer_two,
  input wire logic drive_running,
  input wire logic low_speed_hold,
  output logic [AW-1:0] torque_limit_a,
  output logic torque_limit_a_valid,
  output logic [AW-1:0] torque_limit_b,
  output logic torque_limit_b_valid,
  output logic [AW-1:0] torque_cmd,
  output logic torque_cmd_valid,
  output logic [AW-1:0] torque_current_cmd,
  output logic torque_current_cmd_valid,
  output logic [AW-1:0] speed_limit_fwd,
  output logic speed_limit_fwd_valid,
  output logic [AW-1:0] speed_limit_rev,
  output logic speed_limit_rev_valid,
  output logic [AW-1:0] monitor_value,
  output logic monitor_value_valid,
  output logic ref_loss_detected,
  output logic [AW:0] freq_ref_out,
  output logic decel_to_stop,
  output logic [AW-1:0] ref_active,
  output logic nv_write,
  output logic [AW-1:0] nv_write_data,
  output logic torque_detected_first,
  output logic torque_detected_second,
  output logic low_torque_detected
);

  localparam logic [FW-1:0] FUNC_CODES [NFUNC] = '{FN_TQ_LIM_A, FN_TQ_LIM_B, FN_TQ_CMD,
    FN_TQ_CUR_CMD, FN_SPD_LIM_FWD, FN_SPD_LIM_REV, FN_MONITOR};
  localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);
  localparam logic [8:0] WIN_LAST = 9'(LOSS_WINDOW_TICKS - 1);
  localparam logic [3:0] LSB_LAST = 4'(TIMER_LSB_TICKS - 1);
  localparam logic [3:0] MIN_ON = 4'(MIN_ON_STEPS);

  // Two-stage synchronisers for the analog and key pins.
  logic [AW-1:0] ain_s1_q [3];
  logic [AW-1:0] ain_s2_q [3];
  logic [AW-1:0] freq_s1_q;
  logic [AW-1:0] freq_s2_q;
  logic [1:0] key_s1_q;
  logic [1:0] key_s2_q;
  logic [1:0] key_s3_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int t = 0; t < 3; t++) begin
        ain_s1_q[t] <= '0;
        ain_s2_q[t] <= '0;
      end
      freq_s1_q <= '0;
      freq_s2_q <= '0;
      key_s1_q <= '0;
      key_s2_q <= '0;
      key_s3_q <= '0;
    end else begin
      ain_s1_q[0] <= ain_a;
      ain_s1_q[1] <= ain_b;
      ain_s1_q[2] <= ain_c;
      ain_s2_q <= ain_s1_q;
      freq_s1_q <= ain_freq_raw;
      freq_s2_q <= freq_s1_q;
      key_s1_q <= {save_key, main_power_fail};
      key_s2_q <= key_s1_q;
      key_s3_q <= key_s2_q;
    end
  end

  // Terminal function mapping, one entry per supported function code.
  logic [AW-1:0] map_val_q [NFUNC];
  logic map_vld_q [NFUNC];

  for (genvar f = 0; f < NFUNC; f++) begin : g_map
    logic [AW-1:0] val_d;
    logic vld_d;
    logic allow;
    assign allow = (FUNC_CODES[f] == FN_TQ_CMD || FUNC_CODES[f] == FN_TQ_CUR_CMD) ?
      torque_control_select : 1'b1; // R2
    always_comb begin
      val_d = '0;
      vld_d = 1'b0;
      if (analog_in_a_function == FUNC_CODES[f]) begin // R5
        val_d = ain_s2_q[0];
        vld_d = allow;
      end else if (analog_in_b_function == FUNC_CODES[f]) begin
        val_d = ain_s2_q[1];
        vld_d = allow;
      end else if (analog_in_c_function == FUNC_CODES[f]) begin
        val_d = ain_s2_q[2];
        vld_d = allow;
      end
    end
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        map_val_q[f] <= '0;
        map_vld_q[f] <= 1'b0;
      end else begin
        map_val_q[f] <= vld_d ? val_d : '0;
        map_vld_q[f] <= vld_d;
      end
    end
  end

  assign torque_limit_a = map_val_q[0]; // R1
  assign torque_limit_a_valid = map_vld_q[0];
  assign torque_limit_b = map_val_q[1]; // R1
  assign torque_limit_b_valid = map_vld_q[1];
  assign torque_cmd = map_val_q[2]; // R2
  assign torque_cmd_valid = map_vld_q[2];
  assign torque_current_cmd = map_val_q[3]; // R2
  assign torque_current_cmd_valid = map_vld_q[3];
  assign speed_limit_fwd = map_val_q[4]; // R3
  assign speed_limit_fwd_valid = map_vld_q[4];
  assign speed_limit_rev = map_val_q[5]; // R3
  assign speed_limit_rev_valid = map_vld_q[5];
  assign monitor_value = map_val_q[6]; // R4
  assign monitor_value_valid = map_vld_q[6];

  // Millisecond tick and ten millisecond timer step.
  logic [15:0] tick_cnt_q;
  logic tick_q;
  logic [3:0] lsb_cnt_q;
  logic step_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_LAST); // R21
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lsb_cnt_q <= '0;
      step_q <= 1'b0;
    end else begin
      step_q <= tick_q && (lsb_cnt_q == LSB_LAST); // R21
      if (tick_q) begin
        lsb_cnt_q <= (lsb_cnt_q == LSB_LAST) ? '0 : lsb_cnt_q + 4'h1;
      end
    end
  end

  // Reference loss supervision on the raw synchronised command.
  alrt_loss_t loss_st_q;
  logic [8:0] win_cnt_q;
  logic [AW-1:0] f1_q;
  logic [AW-1:0] f1_lost_q;
  logic [PW-1:0] cur_x10;
  logic [PW-1:0] cur_x100;
  logic [PW-1:0] rec_level;
  logic [RW-1:0] rec_pct;
  logic [PW-1:0] cont_freq;

  assign cur_x10 = PW'(freq_s2_q) * PW'(LOSS_FRACTION_DIV); // R15
  assign cur_x100 = PW'(freq_s2_q) * PW'(PCT_SCALE);
  assign rec_pct = (ref_loss_ratio == LOSS_STOP || ref_loss_ratio == LOSS_OFF) ? REC_PCT_LOW :
    (ref_loss_ratio >= LOSS_FULL) ? PCT_SCALE : ref_loss_ratio; // R12 R13
  assign rec_level = PW'(f1_lost_q) * PW'(rec_pct);
  assign cont_freq = PW'(f1_lost_q) * PW'(ref_loss_ratio) / PW'(PCT_SCALE); // R10

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      loss_st_q <= ALRT_WATCH;
      win_cnt_q <= '0;
      f1_q <= '0;
      f1_lost_q <= '0;
    end else if (tick_q) begin
      case (loss_st_q)
        ALRT_WATCH: begin
          if (cur_x10 < PW'(f1_q)) begin // R8
            loss_st_q <= ALRT_LOST;
            f1_lost_q <= f1_q;
            win_cnt_q <= '0;
          end else if (win_cnt_q == WIN_LAST) begin // R14
            f1_q <= freq_s2_q;
            win_cnt_q <= '0;
          end else begin
            win_cnt_q <= win_cnt_q + 9'h001; // R21
          end
        end
        ALRT_LOST: begin
          if (cur_x100 > rec_level) begin // R9
            loss_st_q <= ALRT_WATCH;
            f1_q <= freq_s2_q;
            win_cnt_q <= '0;
          end
        end
        default: loss_st_q <= ALRT_WATCH;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ref_loss_detected <= 1'b0;
      freq_ref_out <= '0;
      decel_to_stop <= 1'b0;
    end else begin
      ref_loss_detected <= (loss_st_q == ALRT_LOST); // R11
      decel_to_stop <= 1'b0;
      if (loss_st_q != ALRT_LOST || ref_loss_ratio == LOSS_OFF) begin // R11
        freq_ref_out <= (AW + 1)'(freq_s2_q);
      end else if (ref_loss_ratio == LOSS_STOP) begin // R10
        freq_ref_out <= '0;
        decel_to_stop <= 1'b1;
      end else begin
        freq_ref_out <= cont_freq[AW:0]; // R10
      end
    end
  end

  // Keypad reference saving; the stored copy lives in external non-volatile memory.
  logic boot_q;
  logic power_fail_rise;
  logic save_key_rise;
  assign power_fail_rise = key_s2_q[0] && !key_s3_q[0];
  assign save_key_rise = key_s2_q[1] && !key_s3_q[1];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      boot_q <= 1'b1;
      ref_active <= '0;
    end else if (boot_q) begin
      boot_q <= 1'b0;
      ref_active <= nv_read_data; // R6 R7
    end else if (keypad_ref_load) begin
      ref_active <= keypad_ref;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      nv_write <= 1'b0;
      nv_write_data <= '0;
    end else begin
      nv_write <= 1'b0;
      if (!boot_q && ref_save_mode == SAVE_AT_POWER_OFF && power_fail_rise) begin // R6
        nv_write <= 1'b1;
        nv_write_data <= ref_active;
      end else if (!boot_q && ref_save_mode == SAVE_ON_KEY && save_key_rise) begin // R7
        nv_write <= 1'b1;
        nv_write_data <= ref_active;
      end
    end
  end

  // Torque detectors: 0 first high, 1 second high, 2 low torque.
  logic det_q [3];

  for (genvar i = 0; i < 3; i++) begin : g_det
    localparam bit IS_LOW = (i == 2);
    logic [TQW-1:0] level;
    logic [TMW-1:0] timer;
    logic on_cond;
    logic off_cond;
    logic [TMW-1:0] tmr_cnt_q;
    logic [3:0] hold_cnt_q;
    assign level = (i == 0) ? torque_level_one : torque_level_two; // R16 R17
    assign timer = (i == 0) ? torque_timer_one : torque_timer_two; // R16 R17
    assign on_cond = IS_LOW ? (torque_calc < level) : (torque_calc > level); // R19 R20
    assign off_cond = IS_LOW ? ((TQW + 1)'(torque_calc) > (TQW + 1)'(level) + (TQW + 1)'(HYST_PCT)) :
      ((TQW + 1)'(torque_calc) + (TQW + 1)'(HYST_PCT) < (TQW + 1)'(level)); // R19 R20

    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        det_q[i] <= 1'b0;
        tmr_cnt_q <= '0;
        hold_cnt_q <= '0;
      end else if (IS_LOW && !drive_running) begin
        det_q[i] <= 1'b0;
        tmr_cnt_q <= '0;
        hold_cnt_q <= '0;
      end else if (IS_LOW && low_speed_hold) begin
        det_q[i] <= det_q[i];
      end else if (step_q) begin
        if (!det_q[i]) begin
          hold_cnt_q <= '0;
          if (!on_cond) begin
            tmr_cnt_q <= '0;
          end else if (tmr_cnt_q + 16'h0001 >= timer) begin // R18
            det_q[i] <= 1'b1;
            tmr_cnt_q <= '0;
          end else begin
            tmr_cnt_q <= tmr_cnt_q + 16'h0001; // R21
          end
        end else begin
          if (hold_cnt_q != MIN_ON) begin
            hold_cnt_q <= hold_cnt_q + 4'h1;
          end else if (off_cond) begin // R19 R20
            det_q[i] <= 1'b0;
          end
        end
      end
    end
  end

  assign torque_detected_first = det_q[0]; // R16
  assign torque_detected_second = det_q[1]; // R17
  assign low_torque_detected = det_q[2]; // R17

endmodule

// ==== rtl/alrt_pkg.sv ====
// Constants shared by the analog reference loss and torque detection block.
package alrt_pkg;
  localparam int AW = 12;
  localparam int FW = 5;
  localparam int RW = 10;
  localparam int TQW = 9;
  localparam int TMW = 16;
  localparam int PW = AW + 10;
  localparam int NFUNC = 7;

  localparam logic [FW-1:0] FN_TQ_LIM_A = 5'h07;
  localparam logic [FW-1:0] FN_TQ_LIM_B = 5'h08;
  localparam logic [FW-1:0] FN_TQ_CMD = 5'h0A;
  localparam logic [FW-1:0] FN_TQ_CUR_CMD = 5'h0B;
  localparam logic [FW-1:0] FN_SPD_LIM_FWD = 5'h11;
  localparam logic [FW-1:0] FN_SPD_LIM_REV = 5'h12;
  localparam logic [FW-1:0] FN_MONITOR = 5'h14;

  localparam logic [RW-1:0] LOSS_STOP = 10'h000;
  localparam logic [RW-1:0] LOSS_OFF = 10'h3E7;
  localparam logic [RW-1:0] LOSS_FULL = 10'h064;
  localparam logic [RW-1:0] REC_PCT_LOW = 10'h014;
  localparam logic [RW-1:0] PCT_SCALE = 10'h064;
  localparam logic [RW-1:0] LOSS_FRACTION_DIV = 10'h00A;
  localparam logic [TQW-1:0] HYST_PCT = 9'h005;

  localparam logic SAVE_AT_POWER_OFF = 1'b0;
  localparam logic SAVE_ON_KEY = 1'b1;

  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int LOSS_WINDOW_MS = 400;
  localparam int LOSS_WINDOW_TICKS = LOSS_WINDOW_MS / TICK_MS;
  localparam int TIMER_LSB_MS = 10;
  localparam int TIMER_LSB_TICKS = TIMER_LSB_MS / TICK_MS;
  localparam int MIN_ON_MS = 100;
  localparam int MIN_ON_STEPS = MIN_ON_MS / TIMER_LSB_MS;

  typedef enum logic [1:0] {
    ALRT_WATCH = 2'b01,
    ALRT_LOST = 2'b10
  } alrt_loss_t;
endpackage

// ==== sim/alrt_monitor.sv ====
// Concurrent checks on the ports of the analog reference and torque block.
`timescale 1ns/1ns
module alrt_monitor
  import alrt_pkg::*;
#(
  parameter int TICK_DIV = 10
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [AW-1:0] ain_a,
  input wire logic [FW-1:0] analog_in_a_function,
  input wire logic torque_control_select,
  input wire logic ref_save_mode,
  input wire logic save_key,
  input wire logic [RW-1:0] ref_loss_ratio,
  input wire logic torque_limit_a_valid,
  input wire logic torque_cmd_valid,
  input wire logic [AW-1:0] monitor_value,
  input wire logic ref_loss_detected,
  input wire logic [AW:0] freq_ref_out,
  input wire logic decel_to_stop,
  input wire logic nv_write,
  input wire logic [AW-1:0] nv_write_data,
  input wire logic [AW-1:0] ref_active,
  input wire logic torque_detected_first
);
  localparam int MIN_CYC = (MIN_ON_STEPS - 1) * TIMER_LSB_TICKS * TICK_DIV;
  logic [31:0] on_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Counts the cycles the first torque output has been on.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      on_q <= '0;
    end else begin
      on_q <= torque_detected_first ? on_q + 32'h1 : '0;
    end
  end
  property p_lim_a;
    (analog_in_a_function == FN_TQ_LIM_A)[*2] |-> torque_limit_a_valid;
  endproperty
  a_lim_a: assert property (p_lim_a) else $error("limit A not valid");
  property p_tq_off;
    (!torque_control_select)[*2] |-> !torque_cmd_valid;
  endproperty
  a_tq_off: assert property (p_tq_off) else $error("torque command valid");
  property p_mon;
    (analog_in_a_function == FN_MONITOR && $stable(ain_a))[*5] |-> monitor_value == ain_a;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor value wrong");
  property p_stop;
    (ref_loss_detected && ref_loss_ratio == LOSS_STOP)[*3] |-> decel_to_stop && freq_ref_out == '0;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop on loss");
  property p_off;
    (ref_loss_detected && ref_loss_ratio == LOSS_OFF)[*3] |-> !decel_to_stop;
  endproperty
  a_off: assert property (p_off) else $error("stop while disabled");
  property p_nv;
    nv_write |-> nv_write_data == $past(ref_active);
  endproperty
  a_nv: assert property (p_nv) else $error("saved value wrong");
  property p_key;
    $rose(save_key) && ref_save_mode == SAVE_ON_KEY |-> ##[1:5] nv_write;
  endproperty
  a_key: assert property (p_key) else $error("key press not saved");
  property p_min_on;
    $fell(torque_detected_first) |-> on_q >= MIN_CYC;
  endproperty
  a_min_on: assert property (p_min_on) else $error("torque output too short");
  c_loss: cover property ($rose(ref_loss_detected));
  c_save: cover property (nv_write);
  c_td: cover property ($rose(torque_detected_first));
endmodule
bind alrt_core alrt_monitor #(.TICK_DIV(TICK_DIV)) i_alrt_monitor (.*);

// ==== sim/alrt_src_model.sv ====
// Model of the analog command sources wired to the block's terminals.
`timescale 1ns/1ns
module alrt_src_model
  import alrt_pkg::*;
(
  input wire logic [AW-1:0] lv_a,
  input wire logic [AW-1:0] lv_b,
  input wire logic [AW-1:0] lv_c,
  input wire logic [AW-1:0] lv_f,
  input wire logic brk,
  output logic [AW-1:0] ain_a,
  output logic [AW-1:0] ain_b,
  output logic [AW-1:0] ain_c,
  output logic [AW-1:0] ain_freq_raw
);
  // A broken command wire reads zero through the input's pull-down.
  assign ain_a = lv_a;
  assign ain_b = lv_b;
  assign ain_c = lv_c;
  assign ain_freq_raw = brk ? '0 : lv_f;
endmodule

// ==== sim/tb_top.sv ====
// Self-checking testbench of the analog reference and torque block.
`timescale 1ns/1ns
module tb_top;
  import alrt_pkg::*;
  localparam int TD = 10;
  localparam int STEP = TD * TIMER_LSB_TICKS;
  typedef struct {string nm; int sel; logic [13:0] ex;} alrt_note_t;
  logic core_clk = 1'h0, reset = 1'h1, brk = 1'h0, nv_seen = 1'h0;
  logic [AW-1:0] lv_a = '0, lv_b = '0, lv_c = 12'h3C5, lv_f = '0, keypad_ref = '0;
  logic [AW-1:0] nv_read_data = 12'h5A3, ain_a, ain_b, ain_c, ain_freq_raw, nvd = '0;
  logic [FW-1:0] analog_in_a_function = '0, analog_in_b_function = '0, analog_in_c_function = '0;
  logic torque_control_select = 1'h1, ref_save_mode = 1'h0, keypad_ref_load = 1'h0;
  logic main_power_fail = 1'h0, save_key = 1'h0, drive_running = 1'h1, low_speed_hold = 1'h0;
  logic [RW-1:0] ref_loss_ratio = '0;
  logic [TQW-1:0] torque_calc = '0, torque_level_one = 9'h096, torque_level_two = 9'h032;
  logic [TMW-1:0] torque_timer_one = 16'h0003, torque_timer_two = 16'h0001;
  logic [AW-1:0] torque_limit_a, torque_limit_b, torque_cmd, torque_current_cmd;
  logic [AW-1:0] speed_limit_fwd, speed_limit_rev, monitor_value, ref_active, nv_write_data;
  logic torque_limit_a_valid, torque_limit_b_valid, torque_cmd_valid, torque_current_cmd_valid;
  logic speed_limit_fwd_valid, speed_limit_rev_valid, monitor_value_valid, ref_loss_detected;
  logic decel_to_stop, nv_write, torque_detected_first, torque_detected_second, low_torque_detected;
  logic [AW:0] freq_ref_out;
  alrt_note_t q[$];
  event chk_ev;
  int mismatches = 0, n_tests = 0, seed = 6639, cyc = 0;
  alrt_core #(.TICK_DIV(TD)) i_alrt_core (.*);
  alrt_src_model i_alrt_src_model (.*);
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (nv_write === 1'h1) begin
      nv_seen <= 1'h1;
    end
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      stop_test();
    end
  end
  function automatic logic [13:0] obs(int s);
    case (s)
      0: return {1'h0, torque_limit_a_valid, torque_limit_a};
      1: return {1'h0, torque_limit_b_valid, torque_limit_b};
      2: return {1'h0, torque_cmd_valid, torque_cmd};
      3: return {1'h0, torque_current_cmd_valid, torque_current_cmd};
      4: return {1'h0, speed_limit_fwd_valid, speed_limit_fwd};
      5: return {1'h0, speed_limit_rev_valid, speed_limit_rev};
      6: return {1'h0, monitor_value_valid, monitor_value};
      7: return {13'h0, ref_loss_detected};
      8: return {1'h0, freq_ref_out};
      9: return {13'h0, decel_to_stop};
      10: return {2'h0, ref_active};
      11: return {1'h0, nv_seen, nv_write_data};
      default: return {11'h0, torque_detected_first, torque_detected_second, low_torque_detected};
    endcase
  endfunction
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(string nm, logic [13:0] seen, logic [13:0] ex);
    n_tests++;
    if (seen !== ex) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic note(string nm, int s, logic [13:0] ex);
    q.push_back(alrt_note_t'{nm, s, ex});
    ->chk_ev;
  endtask
  task automatic cyc_w(int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Takes every queued expectation off the queue, oldest first, and compares it with the outputs.
  initial begin
    alrt_note_t n;
    forever begin
      @(chk_ev);
      while (q.size() > 0) begin
        n = q.pop_front();
        check(n.nm, obs(n.sel), n.ex);
      end
    end
  end
  initial begin
    logic [FW-1:0] codes [7];
    logic [RW-1:0] rat [4];
    logic [13:0] fx [4];
    logic [AW-1:0] rec [4];
    logic [TQW-1:0] tq [9];
    int st [9];
    logic [2:0] ex [9];
    codes = '{FN_TQ_LIM_A, FN_TQ_LIM_B, FN_TQ_CMD, FN_TQ_CUR_CMD, FN_SPD_LIM_FWD, FN_SPD_LIM_REV,
      FN_MONITOR};
    rat = '{LOSS_STOP, LOSS_OFF, 10'h032, 10'h078};
    fx = '{14'h0, 14'h0, 14'h03E8, 14'h0960};
    rec = '{12'h190, 12'h190, 12'h3E8, 12'h7D0};
    tq = '{9'h0C8, 9'h064, 9'h093, 9'h090, 9'h01E, 9'h035, 9'h038, 9'h01E, 9'h064};
    st = '{6, 3, 15, 3, 12, 15, 3, 5, 15};
    ex = '{3'h6, 3'h6, 3'h6, 3'h2, 3'h1, 3'h3, 3'h2, 3'h1, 3'h3};
    cyc_w(6);
    reset = 1'h0;
    cyc_w(1);
    note("restore", 10, {2'h0, nv_read_data});
    foreach (codes[i]) begin
      analog_in_a_function = codes[i];
      lv_a = AW'($random(seed));
      cyc_w(5);
      note("map", i, {2'h1, lv_a});
    end
    analog_in_b_function = FN_MONITOR;
    lv_b = ~lv_a;
    analog_in_c_function = FN_TQ_CMD;
    torque_control_select = 1'h0;
    cyc_w(5);
    note("prio_a", 6, {2'h1, lv_a});
    note("tq_gate", 2, 14'h0);
    analog_in_a_function = '0;
    torque_control_select = 1'h1;
    cyc_w(5);
    note("prio_b", 6, {2'h1, lv_b});
    note("tq_c", 2, {2'h1, lv_c});
    foreach (rat[i]) begin
      ref_loss_ratio = rat[i];
      lv_f = 12'h7D0;
      cyc_w(850 * TD);
      brk = 1'h1;
      cyc_w(20 * TD);
      note("loss", 7, 14'h1);
      note("loss_freq", 8, fx[i]);
      note("decel", 9, {13'h0, rat[i] == LOSS_STOP});
      brk = 1'h0;
      lv_f = rec[i] - 12'h032;
      cyc_w(20 * TD);
      note("hold", 7, 14'h1);
      lv_f = rec[i] + 12'h032;
      cyc_w(20 * TD);
      note("recover", 7, 14'h0);
      note("follow", 8, {2'h0, lv_f});
    end
    for (int i = 0; i < 4; i++) begin
      if (!i[0]) begin
        keypad_ref = AW'($random(seed));
        keypad_ref_load = 1'h1;
        cyc_w(1);
        keypad_ref_load = 1'h0;
        cyc_w(2);
        note("keypad", 10, {2'h0, keypad_ref});
      end
      ref_save_mode = !i[1];
      nv_seen = 1'h0;
      save_key = (i == 1 || i == 2);
      main_power_fail = !save_key;
      cyc_w(8);
      save_key = 1'h0;
      main_power_fail = 1'h0;
      cyc_w(4);
      if (i[0]) begin
        nvd = keypad_ref;
      end
      note("save", 11, {1'h0, i[0], nvd});
    end
    foreach (tq[i]) begin
      torque_calc = tq[i];
      low_speed_hold = (i == 8);
      cyc_w(st[i] * STEP);
      note("torque", 12, {11'h0, ex[i]});
    end
    drive_running = 1'h0;
    cyc_w(3);
    note("stopped", 12, 14'h2);
    cyc_w(2);
    stop_test();
  end
endmodule
